// >>> verilog/gpar_pkg.sv
// constants and carrier types of the per-port gigabit negotiation registers
// assumes one register-bus master and five negotiation engines in the same clock domain
package gpar_pkg;

  localparam int NUM_PORTS = 5;

  // switch-space offsets of each port's registers (port number in addr[15:12])
  localparam logic [11:0] OFS_NP_RX = 12'h110;
  localparam logic [11:0] OFS_GCTL  = 12'h112;
  localparam logic [11:0] OFS_GSTAT = 12'h114;

  // standard register indexes, reached through the index window
  localparam logic [4:0] IDX_NP_RX = 5'h08;
  localparam logic [4:0] IDX_GCTL  = 5'h09;
  localparam logic [4:0] IDX_GSTAT = 5'h0A;
  localparam logic [3:0] IDX_WIN   = 4'hF;

  // interrupt registers
  localparam logic [15:0] OFS_INT_STAT = 16'h0000;
  localparam logic [15:0] OFS_INT_CLR  = 16'h0002;
  localparam logic [15:0] OFS_INT_EN   = 16'h0004;
  localparam int          INT_FAULT_LO = 0;
  localparam int          INT_SAT_LO   = 5;
  localparam int          INT_W        = 10;

  // received next page fields
  localparam int NP_MORE = 15;
  localparam int NP_ACK  = 14;
  localparam int NP_MSG  = 13;
  localparam int NP_ACK2 = 12;
  localparam int NP_TOG  = 11;

  // gigabit control fields
  localparam int GC_TEST_LO  = 13;
  localparam int GC_MAN_EN   = 12;
  localparam int GC_MAN_VAL  = 11;
  localparam int GC_PORT_TYP = 10;
  localparam int GC_ADV_FD   = 9;
  localparam int GC_ADV_HD   = 8;
  localparam logic [15:0] GCTL_WMASK = 16'hFF00;

  // gigabit status fields
  localparam int GS_FAULT = 15;
  localparam int GS_RES   = 14;
  localparam int GS_LRX   = 13;
  localparam int GS_RRX   = 12;
  localparam int GS_LPFD  = 11;
  localparam int GS_LPHD  = 10;

  // reset values
  localparam logic [15:0] NP_RX_RST = 16'h0000;
  localparam logic [15:0] GCTL_RST  = 16'h0300;
  localparam logic [7:0]  CNT_RST   = 8'h00;
  localparam logic [7:0]  CNT_MAX   = 8'hFF;

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_NP   = 2'b01,
    SEL_CTL  = 2'b11,
    SEL_STAT = 2'b10
  } gpar_sel_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } gpar_bus_req_t;

  typedef struct packed {
    logic        np_valid;
    logic [15:0] np_word;
    logic        ms_fault;
    logic        ms_master;
    logic        loc_rx_ok;
    logic        rem_rx_ok;
    logic        lp_fd;
    logic        lp_hd;
    logic        idle_send_n;
    logic        rx_err;
  } gpar_port_in_t;

  typedef struct packed {
    logic       manual_en;
    logic       force_master;
    logic       prefer_master;
    logic       adv_fd;
    logic       adv_hd;
    logic [2:0] test_mode;
  } gpar_port_cfg_t;

  typedef struct packed {
    logic [15:0]    np_rx;
    logic [15:0]    ctl;
    logic           fault;
    logic [7:0]     idle_cnt;
    gpar_port_cfg_t cfg;
  } gpar_port_state_t;

  typedef struct packed {
    gpar_port_state_t [NUM_PORTS-1:0] port;
    logic [INT_W-1:0]                 int_stat;
    logic [INT_W-1:0]                 int_en;
    logic [15:0]                      rdata;
    logic                             irq;
  } gpar_state_t;

endpackage

// >>> verilog/gpar_regs.sv
// five ports of gigabit negotiation registers: received next page, control, status
// assumes bus strobes and engine inputs synchronous to sys_clk_i; engine pulses last one cycle
//
// Overview of operation
// - three 16-bit registers per port, at switch address and at standard index
// - next page bit 15 shows partner has more next pages following
// - next page bit 14 is read-only, set on partner's successful link word receipt
// - next page bit 13 message versus unformatted; bit 12 partner able to act
// - bit 11 toggle as received; bits 10:0 the partner's read-only message field
// - control bit 12 enables manual master-slave setting, reset value zero
// - control bit 11 forces master or slave, honoured only with manual enabled
// - control bit 10 port type preference, honoured only with manual disabled
// - control bit 9 advertises gigabit full duplex, resets to one
// - control bit 8 advertises gigabit half duplex, resets to one
// - status bit 15 latches master-slave fault, clears on read, resets zero
// - status bit 14 shows master-slave resolution result, one meaning master
// - status bit 13 shows local receiver status
// - status bit 12 shows remote receiver status
// - status bits 11 and 10 show partner gigabit full and half duplex ability
// - status bits 7:0 idle error count, cleared on read, resets zero
// - count rises by one per symbol with receive error during idle reception, holding at 255
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns

module gpar_regs (
  input  wire logic                                    sys_clk_i,
  input  wire logic                                    rst_n_i,
  input  wire gpar_pkg::gpar_bus_req_t                 bus_i,
  output logic [15:0]                                  rdata_o,
  output logic                                         irq_o,
  input  wire gpar_pkg::gpar_port_in_t  [gpar_pkg::NUM_PORTS-1:0] port_i,
  output gpar_pkg::gpar_port_cfg_t      [gpar_pkg::NUM_PORTS-1:0] cfg_o
);
  import gpar_pkg::*;

  logic [1:0]  rst_sync_q;
  logic        rst_n;
  gpar_state_t q;
  gpar_state_t d;

  logic [NUM_PORTS-1:0] ev_fault;
  logic [NUM_PORTS-1:0] ev_sat;
  gpar_sel_t [NUM_PORTS-1:0] sel;

  // reset release through two flops
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // which of a port's registers the bus address selects, either address form
  function automatic gpar_sel_t reg_sel(input logic [15:0] a, input logic [3:0] pnum);
    gpar_sel_t s;
    s = SEL_NONE;
    if (a[15:12] == pnum) begin
      if (a[11:0] == OFS_NP_RX) begin
        s = SEL_NP;
      end else if (a[11:0] == OFS_GCTL) begin
        s = SEL_CTL;
      end else if (a[11:0] == OFS_GSTAT) begin
        s = SEL_STAT;
      end
    end else if (a[15:12] == IDX_WIN && a[11:8] == 4'h0 && {1'b0, a[7:5]} == pnum) begin
      if (a[4:0] == IDX_NP_RX) begin
        s = SEL_NP;
      end else if (a[4:0] == IDX_GCTL) begin
        s = SEL_CTL;
      end else if (a[4:0] == IDX_GSTAT) begin
        s = SEL_STAT;
      end
    end
    return s;
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_sel
      assign sel[g] = reg_sel(bus_i.addr, 4'(g + 1));
    end
  endgenerate

  always_comb begin
    logic       inc;
    logic [7:0] base;
    logic       stat_rd;
    inc     = 1'b0;
    base    = CNT_RST;
    stat_rd = 1'b0;
    d        = q;
    d.rdata  = 16'h0000;
    ev_fault = '0;
    ev_sat   = '0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      // received next page: whole word taken from the engine, bit 15 also writable
      if (port_i[p].np_valid) begin
        d.port[p].np_rx = port_i[p].np_word;
      end else if (bus_i.wr && sel[p] == SEL_NP) begin
        d.port[p].np_rx[NP_MORE] = bus_i.wdata[NP_MORE];
      end

      // control: only bits 15:8 store, reserved low byte reads zero
      if (bus_i.wr && sel[p] == SEL_CTL) begin
        d.port[p].ctl = bus_i.wdata & GCTL_WMASK;
      end
      d.port[p].cfg.manual_en     = d.port[p].ctl[GC_MAN_EN];
      d.port[p].cfg.force_master  = d.port[p].ctl[GC_MAN_EN]
                                    & d.port[p].ctl[GC_MAN_VAL];
      d.port[p].cfg.prefer_master = ~d.port[p].ctl[GC_MAN_EN]
                                    & d.port[p].ctl[GC_PORT_TYP];
      d.port[p].cfg.adv_fd        = d.port[p].ctl[GC_ADV_FD];
      d.port[p].cfg.adv_hd        = d.port[p].ctl[GC_ADV_HD];
      d.port[p].cfg.test_mode     = d.port[p].ctl[GC_TEST_LO +: 3];

      // status read clears the fault latch and the counter; a new event wins
      stat_rd = bus_i.rd && sel[p] == SEL_STAT;
      if (stat_rd) begin
        d.port[p].fault = 1'b0;
      end
      if (port_i[p].ms_fault) begin
        d.port[p].fault = 1'b1;
        ev_fault[p]     = 1'b1;
      end

      base = stat_rd ? CNT_RST : q.port[p].idle_cnt;
      inc  = port_i[p].idle_send_n && port_i[p].rx_err && base != CNT_MAX;
      d.port[p].idle_cnt = base + {7'h00, inc};
      ev_sat[p] = inc && base == CNT_MAX - 8'h01;

      if (bus_i.rd) begin
        unique case (sel[p])
          SEL_NP: begin
            d.rdata = q.port[p].np_rx;
          end
          SEL_CTL: begin
            d.rdata = q.port[p].ctl;
          end
          SEL_STAT: begin
            d.rdata[GS_FAULT] = q.port[p].fault;
            d.rdata[GS_RES]   = port_i[p].ms_master;
            d.rdata[GS_LRX]   = port_i[p].loc_rx_ok;
            d.rdata[GS_RRX]   = port_i[p].rem_rx_ok;
            d.rdata[GS_LPFD]  = port_i[p].lp_fd;
            d.rdata[GS_LPHD]  = port_i[p].lp_hd;
            d.rdata[7:0]      = q.port[p].idle_cnt;
          end
          SEL_NONE: begin
          end
        endcase
      end
    end

    // interrupt status: write-one-to-clear, a same-cycle event stays set
    if (bus_i.wr && bus_i.addr == OFS_INT_CLR) begin
      d.int_stat = q.int_stat & ~bus_i.wdata[INT_W-1:0];
    end
    d.int_stat[INT_FAULT_LO +: NUM_PORTS] = d.int_stat[INT_FAULT_LO +: NUM_PORTS] | ev_fault;
    d.int_stat[INT_SAT_LO +: NUM_PORTS]   = d.int_stat[INT_SAT_LO +: NUM_PORTS] | ev_sat;
    if (bus_i.wr && bus_i.addr == OFS_INT_EN) begin
      d.int_en = bus_i.wdata[INT_W-1:0];
    end
    if (bus_i.rd && bus_i.addr == OFS_INT_STAT) begin
      d.rdata = {6'h00, q.int_stat};
    end else if (bus_i.rd && bus_i.addr == OFS_INT_EN) begin
      d.rdata = {6'h00, q.int_en};
    end
    d.irq = |(d.int_stat & d.int_en);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        q.port[p].np_rx      <= NP_RX_RST;
        q.port[p].ctl        <= GCTL_RST;
        q.port[p].cfg.adv_fd <= 1'b1;
        q.port[p].cfg.adv_hd <= 1'b1;
        q.port[p].idle_cnt   <= CNT_RST;
      end
    end else begin
      q <= d;
    end
  end

  assign rdata_o = q.rdata;
  assign irq_o   = q.irq;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_cfg
      assign cfg_o[g] = q.port[g].cfg;
    end
  endgenerate

  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n);

  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_chk
      a_fault_latch_set: assert property (
        port_i[g].ms_fault |=> q.port[g].fault && q.int_stat[INT_FAULT_LO + g])
        else $error("fault event not latched");

      a_fault_read_clear: assert property (
        bus_i.rd && sel[g] == SEL_STAT && !port_i[g].ms_fault |=> !q.port[g].fault)
        else $error("fault bit not cleared by status read");

      a_fault_read_value: assert property (
        bus_i.rd && sel[g] == SEL_STAT |=> rdata_o[GS_FAULT] == $past(q.port[g].fault))
        else $error("fault bit read back wrong");

      a_count_step: assert property (
        port_i[g].idle_send_n && port_i[g].rx_err && q.port[g].idle_cnt != CNT_MAX
        && !(bus_i.rd && sel[g] == SEL_STAT)
        |=> q.port[g].idle_cnt == $past(q.port[g].idle_cnt) + 8'h01)
        else $error("idle error count did not step by one");

      a_count_idle_hold: assert property (
        !(port_i[g].idle_send_n && port_i[g].rx_err) && !(bus_i.rd && sel[g] == SEL_STAT)
        |=> $stable(q.port[g].idle_cnt))
        else $error("idle error count moved without an error");

      a_count_saturate: assert property (
        q.port[g].idle_cnt == CNT_MAX && !(bus_i.rd && sel[g] == SEL_STAT)
        |=> q.port[g].idle_cnt == CNT_MAX [*2] or
            (q.port[g].idle_cnt == CNT_MAX ##1 $past(bus_i.rd)))
        else $error("idle error count left saturation without a read");

      a_count_read_clear: assert property (
        bus_i.rd && sel[g] == SEL_STAT
        |=> rdata_o[7:0] == $past(q.port[g].idle_cnt)
            && q.port[g].idle_cnt <= 8'h01)
        else $error("idle error count not returned and cleared");

      a_force_gated: assert property (
        cfg_o[g].force_master |-> cfg_o[g].manual_en && q.port[g].ctl[GC_MAN_VAL])
        else $error("force master without manual enable");

      a_prefer_gated: assert property (
        bus_i.wr && sel[g] == SEL_CTL && bus_i.wdata[GC_MAN_EN]
        |=> !cfg_o[g].prefer_master ##1 !cfg_o[g].prefer_master || $past(bus_i.wr))
        else $error("port type honoured under manual configuration");

      a_page_capture: assert property (
        port_i[g].np_valid |=> q.port[g].np_rx == $past(port_i[g].np_word))
        else $error("received next page not captured");

      a_ctl_readback: assert property (
        bus_i.wr && sel[g] == SEL_CTL ##1 !bus_i.wr
        ##1 bus_i.rd && sel[g] == SEL_CTL
        |=> rdata_o == ($past(bus_i.wdata, 3) & GCTL_WMASK))
        else $error("control register read back wrong");

      a_status_live: assert property (
        bus_i.rd && sel[g] == SEL_STAT
        |=> rdata_o[GS_RES] == $past(port_i[g].ms_master)
            && rdata_o[GS_LRX] == $past(port_i[g].loc_rx_ok)
            && rdata_o[GS_LPFD] == $past(port_i[g].lp_fd))
        else $error("status levels read back wrong");

      a_page_more_write: assert property (
        bus_i.wr && sel[g] == SEL_NP && !port_i[g].np_valid
        |=> q.port[g].np_rx[NP_MORE] == $past(bus_i.wdata[NP_MORE])
            && q.port[g].np_rx[NP_ACK:0] == $past(q.port[g].np_rx[NP_ACK:0]))
        else $error("next page write touched a read-only bit");

      a_page_hold: assert property (
        !port_i[g].np_valid && !(bus_i.wr && sel[g] == SEL_NP)
        |=> $stable(q.port[g].np_rx))
        else $error("received next page changed without a page");

      a_page_readback: assert property (
        bus_i.rd && sel[g] == SEL_NP |=> rdata_o == $past(q.port[g].np_rx))
        else $error("received next page read back wrong");

      a_ctl_reserved: assert property (
        q.port[g].ctl[7:0] == 8'h00)
        else $error("reserved control bits stored");

      a_ctl_hold: assert property (
        !(bus_i.wr && sel[g] == SEL_CTL)
        |=> $stable(q.port[g].ctl))
        else $error("control register changed without a write");

      a_manual_follow: assert property (
        cfg_o[g].manual_en == q.port[g].ctl[GC_MAN_EN])
        else $error("manual enable output differs from control");

      a_prefer_follow: assert property (
        cfg_o[g].prefer_master
        == (!q.port[g].ctl[GC_MAN_EN] && q.port[g].ctl[GC_PORT_TYP]))
        else $error("port type output differs from control");

      a_adv_full: assert property (
        cfg_o[g].adv_fd == q.port[g].ctl[GC_ADV_FD])
        else $error("full duplex advertisement differs from control");

      a_adv_half: assert property (
        cfg_o[g].adv_hd == q.port[g].ctl[GC_ADV_HD])
        else $error("half duplex advertisement differs from control");

      a_test_mode: assert property (
        cfg_o[g].test_mode == q.port[g].ctl[GC_TEST_LO +: 3])
        else $error("test mode output differs from control");

      a_status_remote: assert property (
        bus_i.rd && sel[g] == SEL_STAT
        |=> rdata_o[GS_RRX] == $past(port_i[g].rem_rx_ok)
            && rdata_o[GS_LPHD] == $past(port_i[g].lp_hd) && rdata_o[9:8] == 2'b00)
        else $error("remote status levels read back wrong");

      a_fault_hold: assert property (
        q.port[g].fault && !(bus_i.rd && sel[g] == SEL_STAT)
        |=> q.port[g].fault)
        else $error("fault latch dropped without a read");

      a_count_no_wrap: assert property (
        q.port[g].idle_cnt == CNT_MAX
        |=> q.port[g].idle_cnt == CNT_MAX || $past(bus_i.rd && sel[g] == SEL_STAT))
        else $error("idle error count wrapped");

      a_sat_flag: assert property (
        q.port[g].idle_cnt == CNT_MAX - 8'h01 && port_i[g].idle_send_n && port_i[g].rx_err
        && !(bus_i.rd && sel[g] == SEL_STAT)
        |=> q.port[g].idle_cnt == CNT_MAX && q.int_stat[INT_SAT_LO + g])
        else $error("saturation event not flagged");
    end
  endgenerate

  a_irq_level: assert property (
    ##1 irq_o == |($past(d.int_stat) & $past(d.int_en)))
    else $error("interrupt output does not follow enabled status");

  a_unmapped_zero: assert property (
    bus_i.rd && sel == '0 && bus_i.addr != OFS_INT_STAT && bus_i.addr != OFS_INT_EN
    |=> rdata_o == 16'h0000)
    else $error("unmapped read returned nonzero");

  a_rdata_idle: assert property (
    !bus_i.rd |=> rdata_o == 16'h0000)
    else $error("read data present without a read");

  // interrupt registers: enable stores, clear needs a one, set wins over clear
  a_int_en_write: assert property (
    bus_i.wr && bus_i.addr == OFS_INT_EN |=> q.int_en == $past(bus_i.wdata[INT_W-1:0]))
    else $error("interrupt enable write lost");

  a_int_clear: assert property (
    bus_i.wr && bus_i.addr == OFS_INT_CLR
    |=> (q.int_stat & $past(bus_i.wdata[INT_W-1:0]) & ~$past({ev_sat, ev_fault})) == '0)
    else $error("interrupt status not cleared by write");

  a_int_sticky: assert property (
    !(bus_i.wr && bus_i.addr == OFS_INT_CLR)
    |=> (q.int_stat & $past(q.int_stat)) == $past(q.int_stat))
    else $error("interrupt status dropped without a clear");

  c_fault_read: cover property (
    port_i[0].ms_fault ##[1:4] bus_i.rd && sel[0] == SEL_STAT);

  c_count_saturated: cover property (
    q.port[2].idle_cnt == CNT_MAX ##1 bus_i.rd && sel[2] == SEL_STAT);

  c_page_read: cover property (bus_i.rd && sel[0] == SEL_NP);

  c_manual_master: cover property (cfg_o[2].force_master);

  c_irq_raised: cover property ($rose(irq_o));

endmodule

// >>> verif/gpar_peer.sv
// negotiation engine model: pages, faults, status levels and idle errors per port
// assumes the bench calls its tasks from a process synchronous to sys_clk_i
`timescale 1ns/1ns
module gpar_peer (
  input  wire logic                                         sys_clk_i,
  output gpar_pkg::gpar_port_in_t [gpar_pkg::NUM_PORTS-1:0] port_o
);
  import gpar_pkg::*;

  initial port_o = '0;

  task automatic page(input int p, input logic [15:0] w);
    @(posedge sys_clk_i);
    port_o[p].np_valid <= 1'b1;
    port_o[p].np_word  <= w;
    @(posedge sys_clk_i);
    port_o[p].np_valid <= 1'b0;
    // word is not held once the pulse ends
    port_o[p].np_word  <= ~w;
  endtask

  task automatic fault(input int p);
    @(posedge sys_clk_i);
    port_o[p].ms_fault <= 1'b1;
    @(posedge sys_clk_i);
    port_o[p].ms_fault <= 1'b0;
  endtask

  task automatic lvl(input int p, input logic [4:0] v);
    @(posedge sys_clk_i);
    {port_o[p].ms_master, port_o[p].loc_rx_ok, port_o[p].rem_rx_ok,
     port_o[p].lp_fd, port_o[p].lp_hd} <= v;
  endtask

  // one clock is one symbol period
  task automatic errs(input int p, input int n, input logic idle);
    @(posedge sys_clk_i);
    port_o[p].idle_send_n <= idle;
    port_o[p].rx_err      <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    port_o[p].idle_send_n <= 1'b0;
    port_o[p].rx_err      <= 1'b0;
  endtask
endmodule

// >>> verif/tb.sv
// bench for the per-port negotiation registers: random and corner accesses
// assumes gpar_regs on one clock and the gpar_peer engine model
`timescale 1ns/1ns
module tb;
  import gpar_pkg::*;
  logic                           sys_clk_i = 1'b0;
  logic                           rst_n_i   = 1'b0;
  gpar_bus_req_t                  bus_q     = '0;
  logic [15:0]                    rdata;
  logic                           irq;
  gpar_port_in_t  [NUM_PORTS-1:0] port;
  gpar_port_cfg_t [NUM_PORTS-1:0] cfg;
  int                             fails     = 0;
  int                             n_checks  = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  gpar_regs gpar_regs_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_i(bus_q),
    .rdata_o(rdata), .irq_o(irq), .port_i(port), .cfg_o(cfg));
  gpar_peer gpar_peer_i (.sys_clk_i(sys_clk_i), .port_o(port));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    bus_q <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk_i);
    bus_q.wr <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge sys_clk_i);
    bus_q <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk_i);
    bus_q.rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask

  task automatic irq_chk(input logic exp);
    repeat (2) @(posedge sys_clk_i);
    #1 chk({15'h0000, irq}, {15'h0000, exp});
  endtask

  function automatic logic [15:0] cfg_exp(input logic [15:0] c);
    return {8'h00, c[12], c[12] & c[11], ~c[12] & c[10], c[9], c[8], c[15:13]};
  endfunction

  // switch form or index-window form of port n, register k
  function automatic logic [15:0] ad(input int n, input int k, input logic ix);
    return ix ? (16'hF000 | 16'(n << 5) | 16'(8 + k)) : (16'(n << 12) | 16'h0110 | 16'(2 * k));
  endfunction

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    fails++;
    finish_test();
  end

  initial begin
    logic [15:0] v;
    logic [15:0] w;
    int          p;
    int          n;
    void'($urandom(32'h59c6));
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    for (p = 1; p <= NUM_PORTS; p++) begin
      rchk(ad(p, 0, 0), 16'h0000);
      rchk(ad(p, 1, 1), 16'h0300);
      rchk(ad(p, 2, 0), 16'h0000);
      chk({8'h00, cfg[p-1]}, cfg_exp(16'h0300));
    end
    $display("test reset done");
    for (n = 0; n < 24; n++) begin
      p = (n < 4) ? 3 : $urandom_range(NUM_PORTS, 1);
      v = (n < 4) ? {3'b101, n[1], n[0], ~n[0], 10'h155} : 16'($urandom);
      wr(ad(p, 1, n[0]), v);
      rchk(ad(p, 1, ~n[0]), v & GCTL_WMASK);
      chk({8'h00, cfg[p-1]}, cfg_exp(v));
    end
    $display("test control done");
    for (n = 0; n < 8; n++) begin
      p = $urandom_range(NUM_PORTS, 1);
      w = (n == 0) ? 16'hFFFF : (n == 1) ? 16'h0000 : 16'($urandom);
      gpar_peer_i.page(p - 1, w);
      rchk(ad(p, 0, n[0]), w);
      wr(ad(p, 0, 0), ~w);
      rchk(ad(p, 0, 1), {~w[15], w[14:0]});
    end
    $display("test next page done");
    for (n = 0; n < 10; n++) begin
      p = $urandom_range(NUM_PORTS, 1);
      v = 16'($urandom);
      gpar_peer_i.lvl(p - 1, v[14:10]);
      rchk(ad(p, 2, n[0]), {1'b0, v[14:10], 10'h000});
    end
    rchk(16'h1116, 16'h0000);
    $display("test status done");
    for (p = 0; p < NUM_PORTS; p++) begin
      gpar_peer_i.lvl(p, 5'h00);
    end
    gpar_peer_i.fault(0);
    irq_chk(1'b0);
    wr(OFS_INT_EN, 16'h03FF);
    irq_chk(1'b1);
    rchk(OFS_INT_EN, 16'h03FF);
    for (p = 1; p <= NUM_PORTS; p++) begin
      gpar_peer_i.fault(p - 1);
      rchk(OFS_INT_STAT, 16'(1 << (p - 1)));
      rchk(ad(p, 2, p[0]), 16'h8000);
      rchk(ad(p, 2, 0), 16'h0000);
      wr(OFS_INT_CLR, 16'h03FF);
      rchk(OFS_INT_STAT, 16'h0000);
      #1 chk({15'h0000, irq}, 16'h0000);
    end
    $display("test fault done");
    for (p = 1; p <= NUM_PORTS; p++) begin
      n = $urandom_range(40, 1);
      gpar_peer_i.errs(p - 1, n, 1'b1);
      gpar_peer_i.errs(p - 1, 7, 1'b0);
      rchk(ad(p, 2, p[0]), 16'(n));
      rchk(ad(p, 2, 0), 16'h0000);
    end
    gpar_peer_i.errs(2, 255, 1'b1);
    gpar_peer_i.errs(2, 45, 1'b1);
    irq_chk(1'b1);
    rchk(OFS_INT_STAT, 16'h0080);
    rchk(ad(3, 2, 1), 16'h00FF);
    rchk(ad(3, 2, 0), 16'h0000);
    $display("test idle count done");
    finish_test();
  end
endmodule
